// ---- logic/btsc_decode.sv ----
// decode and execute for set-bit, bit tests with skip, and call
`timescale 1ns/100ps
`default_nettype none
module btsc_decode (
  input  wire logic                           ref_clk,
  input  wire logic                           reset_n,
  input  wire logic [btsc_pkg::WORD_W-1:0]    prog_data,
  output logic      [btsc_pkg::PC_W-1:0]      prog_addr,
  output logic      [btsc_pkg::ADDR_W-1:0]    file_addr,
  input  wire logic [7:0]                     file_rdata,
  output logic      [7:0]                     file_wdata,
  output logic                                file_we,
  input  wire logic [btsc_pkg::LATCH_W-1:0]   pc_upper_latch,
  output logic      [btsc_pkg::PC_W-1:0]      return_stack_top,
  output logic                                stack_push,
  output logic                                status_we,
  output logic      [1:0]                     phase
);
  // ****************************************
  // state
  // ****************************************
  typedef enum {BTSC_RUN, BTSC_IDLE} btsc_state_t;
  btsc_state_t state;
  btsc_state_t next_state;
  logic [btsc_pkg::WORD_W-1:0] ir;
  logic [btsc_pkg::WORD_W-1:0] next_ir;
  logic [btsc_pkg::PC_W-1:0]   pc;
  logic [btsc_pkg::PC_W-1:0]   next_pc;
  logic [btsc_pkg::ADDR_W-1:0] next_file_addr;
  logic [7:0]                  data;
  logic [7:0]                  next_data;
  logic [7:0]                  next_file_wdata;
  logic                        next_file_we;
  logic [btsc_pkg::PC_W-1:0]   next_tos;
  logic                        next_push;
  logic                        hit;
  logic                        next_hit;

  btsc_phase_gen u_phase (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .phase   (phase)
  );

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_op4(input logic [btsc_pkg::WORD_W-1:0] w,
                                  input logic [3:0] op);
    is_op4 = (w[btsc_pkg::WORD_W-1:btsc_pkg::OP4_LSB] == op);
  endfunction

  function automatic logic [7:0] bit_mask(input logic [btsc_pkg::WORD_W-1:0] w);
    bit_mask = 8'h01 << w[btsc_pkg::BIT_LSB +: btsc_pkg::BIT_W];
  endfunction

  logic op_set;
  logic op_zero;
  logic op_one;
  logic op_call;
  assign op_set  = is_op4(ir, btsc_pkg::OP_SET_BIT);
  assign op_zero = is_op4(ir, btsc_pkg::OP_SKIP_ZERO);
  assign op_one  = is_op4(ir, btsc_pkg::OP_SKIP_ONE);
  assign op_call = (ir[btsc_pkg::WORD_W-1:btsc_pkg::OP3_LSB] == btsc_pkg::OP_CALL);

  assign prog_addr = pc;
  // flags are never written by this block
  assign status_we = 1'b0;

  // ****************************************
  // phase sequencing
  // ****************************************
  always_comb begin
    next_state      = state;
    next_ir         = ir;
    next_pc         = pc;
    next_file_addr  = file_addr;
    next_data       = data;
    next_file_wdata = file_wdata;
    next_file_we    = 1'b0;
    next_tos        = return_stack_top;
    next_push       = 1'b0;
    next_hit        = hit;
    unique case (phase)
      btsc_pkg::PH_DECODE: begin
        next_hit       = 1'b0;
        next_file_addr = ir[btsc_pkg::ADDR_LSB +: btsc_pkg::ADDR_W];
      end
      btsc_pkg::PH_READ: begin
        next_data = file_rdata;
        if (state == BTSC_RUN && op_call) begin
          next_tos  = pc;
          next_push = 1'b1;
        end
      end
      btsc_pkg::PH_PROCESS: begin
        if (state == BTSC_RUN) begin
          if (op_set) begin
            next_file_wdata = data | bit_mask(ir);
          end
          // zero test skips on a clear bit, one test on a set bit
          if (op_zero) begin
            next_hit = ((data & bit_mask(ir)) == 8'h00);
          end
          if (op_one) begin
            next_hit = ((data & bit_mask(ir)) != 8'h00);
          end
        end
      end
      btsc_pkg::PH_WRITE: begin
        if (state == BTSC_RUN && op_set) begin
          next_file_we = 1'b1;
        end
        if (state == BTSC_RUN && op_call) begin
          next_pc = {pc_upper_latch[btsc_pkg::LATCH_HI_LSB +: 2],
                     ir[btsc_pkg::LIT_W-1:0]};
        end else begin
          next_pc = pc + 13'h0001;
        end
        // skipped or redirected word becomes an idle cycle
        if (state == BTSC_RUN && (hit || op_call)) begin
          next_ir    = btsc_pkg::NOP_WORD;
          next_state = BTSC_IDLE;
        end else begin
          next_ir    = prog_data;
          next_state = BTSC_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state            <= BTSC_RUN;
      ir               <= btsc_pkg::NOP_WORD;
      pc               <= btsc_pkg::PC_RESET;
      file_addr        <= 7'h00;
      data             <= 8'h00;
      file_wdata       <= 8'h00;
      file_we          <= 1'b0;
      return_stack_top <= btsc_pkg::PC_RESET;
      stack_push       <= 1'b0;
      hit              <= 1'b0;
    end else begin
      state            <= next_state;
      ir               <= next_ir;
      pc               <= next_pc;
      file_addr        <= next_file_addr;
      data             <= next_data;
      file_wdata       <= next_file_wdata;
      file_we          <= next_file_we;
      return_stack_top <= next_tos;
      stack_push       <= next_push;
      hit              <= next_hit;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_call_write;
    phase == btsc_pkg::PH_WRITE && state == BTSC_RUN && op_call;
  endsequence

  property p_call_target;
    @(posedge ref_clk) disable iff (!reset_n)
      s_call_write |=> pc == {$past(pc_upper_latch[btsc_pkg::LATCH_HI_LSB +: 2]),
                              $past(ir[btsc_pkg::LIT_W-1:0])};
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");

  property p_call_idle;
    @(posedge ref_clk) disable iff (!reset_n)
      s_call_write |=> state == BTSC_IDLE && ir == btsc_pkg::NOP_WORD;
  endproperty
  a_call_idle: assert property (p_call_idle) else $error("call not followed by idle");

  property p_push;
    @(posedge ref_clk) disable iff (!reset_n)
      stack_push |-> return_stack_top == pc && $past(phase) == btsc_pkg::PH_READ;
  endproperty
  a_push: assert property (p_push) else $error("push value or timing wrong");

  property p_set_write;
    @(posedge ref_clk) disable iff (!reset_n)
      // ir already holds the next word when the strobe shows, so look one clock back
      file_we |-> $past(op_set) && file_wdata == ($past(data) | bit_mask($past(ir)));
  endproperty
  a_set_write: assert property (p_set_write) else $error("set write wrong");

  property p_test_no_write;
    @(posedge ref_clk) disable iff (!reset_n)
      (phase == btsc_pkg::PH_WRITE && state == BTSC_RUN && (op_zero || op_one)) |=> !file_we;
  endproperty
  a_test_no_write: assert property (p_test_no_write) else $error("test wrote");

  property p_skip_zero;
    @(posedge ref_clk) disable iff (!reset_n)
      (phase == btsc_pkg::PH_PROCESS && state == BTSC_RUN && op_zero
       && (data & bit_mask(ir)) == 8'h00) |=> ##1 state == BTSC_IDLE;
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero skip missed");

  property p_skip_one;
    @(posedge ref_clk) disable iff (!reset_n)
      (phase == btsc_pkg::PH_PROCESS && state == BTSC_RUN && op_one
       && (data & bit_mask(ir)) == 8'h00) |=> ##1 state == BTSC_RUN;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("one test skipped wrongly");

  property p_skip_one_hit;
    @(posedge ref_clk) disable iff (!reset_n)
      (phase == btsc_pkg::PH_PROCESS && state == BTSC_RUN && op_one
       && (data & bit_mask(ir)) != 8'h00) |=> ##1 state == BTSC_IDLE;
  endproperty
  a_skip_one_hit: assert property (p_skip_one_hit) else $error("one skip missed");

  property p_skip_zero_miss;
    @(posedge ref_clk) disable iff (!reset_n)
      (phase == btsc_pkg::PH_PROCESS && state == BTSC_RUN && op_zero
       && (data & bit_mask(ir)) != 8'h00) |=> ##1 state == BTSC_RUN;
  endproperty
  a_skip_zero_miss: assert property (p_skip_zero_miss) else $error("zero test skipped wrongly");

  property p_idle_once;
    @(posedge ref_clk) disable iff (!reset_n)
      (phase == btsc_pkg::PH_WRITE && state == BTSC_IDLE) |=> state == BTSC_RUN;
  endproperty
  a_idle_once: assert property (p_idle_once) else $error("idle cycle too long");

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!reset_n)
      state == BTSC_IDLE |-> !stack_push && !file_we;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle cycle acted");

  property p_flags;
    @(posedge ref_clk) disable iff (!reset_n)
      !status_we;
  endproperty
  a_flags: assert property (p_flags) else $error("flags touched");
endmodule
`default_nettype wire

// ---- logic/btsc_phase_gen.sv ----
// four-phase generator for the instruction cycle
`timescale 1ns/100ps
`default_nettype none
module btsc_phase_gen (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  output logic [1:0]      phase
);
  logic [1:0] next_phase;

  always_comb begin
    next_phase = phase + 2'h1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= btsc_pkg::PH_DECODE;
    end else begin
      phase <= next_phase;
    end
  end
endmodule
`default_nettype wire

// ---- shared/btsc_pkg.sv ----
// constants for the bit-test, skip and call decode block
package btsc_pkg;
  localparam int unsigned WORD_W      = 14;
  localparam int unsigned PC_W        = 13;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned BIT_W       = 3;
  localparam int unsigned LIT_W       = 11;
  localparam int unsigned LATCH_W     = 8;
  // opcode fields
  localparam logic [3:0] OP_SET_BIT   = 4'h5;
  localparam logic [3:0] OP_SKIP_ZERO = 4'h6;
  localparam logic [3:0] OP_SKIP_ONE  = 4'h7;
  localparam logic [2:0] OP_CALL      = 3'h4;
  localparam int unsigned OP4_LSB     = 10;
  localparam int unsigned OP3_LSB     = 11;
  localparam int unsigned BIT_LSB     = 7;
  localparam int unsigned ADDR_LSB    = 0;
  localparam int unsigned LATCH_HI_LSB = 3;
  localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;
  localparam logic [PC_W-1:0]   PC_RESET = 13'h0000;
  localparam logic [1:0]        PH_DECODE  = 2'h0;
  localparam logic [1:0]        PH_READ    = 2'h1;
  localparam logic [1:0]        PH_PROCESS = 2'h2;
  localparam logic [1:0]        PH_WRITE   = 2'h3;
  // core clock period and instruction cycle
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned CYCLE_NS    = 200;
  localparam int unsigned PHASES      = CYCLE_NS / CLK_NS;
endpackage

// ---- tb/bit_test_skip_call_decode_tb.sv ----
// self-checking bench for the bit-test, skip and call decoder
`timescale 1ns/100ps
`default_nettype none
module bit_test_skip_call_decode_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  pc_upper_latch = 8'h00;
  logic [13:0] prog_data;
  logic [12:0] prog_addr;
  logic [6:0]  file_addr;
  logic [7:0]  file_rdata;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [12:0] return_stack_top;
  logic        stack_push;
  logic        status_we;
  logic [1:0]  phase;
  int          err_total = 0;
  int          comparisons = 0;
  int          cycles = 0;
  btsc_decode i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .prog_data(prog_data),
    .prog_addr(prog_addr), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we), .pc_upper_latch(pc_upper_latch),
    .return_stack_top(return_stack_top), .stack_push(stack_push),
    .status_we(status_we), .phase(phase));
  btsc_mem_model i_mem (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_wdata(file_wdata),
    .file_we(file_we), .return_stack_top(return_stack_top), .stack_push(stack_push));
  // ****************************************
  // helpers
  // ****************************************
  initial forever #25 ref_clk = ~ref_clk;
  // ceiling well above the eight short programs
  always @(posedge ref_clk) begin
    cycles++;
    if (status_we !== 1'b0) chk({15'h0, status_we}, 16'h0000);
    if (cycles == 2000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [13:0] bw(logic [3:0] op, logic [2:0] b, logic [6:0] f);
    return {op, b, f};
  endfunction
  task automatic restart;
    for (int a = 0; a < 8192; a++) i_mem.mem[a] = btsc_pkg::NOP_WORD;
    for (int a = 0; a < 128; a++) i_mem.regs[a] = 8'h00;
    i_mem.wr_count = 0;
    i_mem.push_count = 0;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_phases;
    restart();
    #1 chk({14'h0, phase}, 16'h0000);
    for (int i = 1; i < 6; i++) begin
      @(posedge ref_clk);
      #1 chk({14'h0, phase}, 16'(i % 4));
    end
  endtask
  task automatic test_set;
    restart();
    i_mem.regs[7'h7f] = 8'h0a;
    i_mem.regs[7'h00] = 8'hfe;
    i_mem.mem[0] = bw(btsc_pkg::OP_SET_BIT, 3'h7, 7'h7f);
    i_mem.mem[1] = bw(btsc_pkg::OP_SET_BIT, 3'h0, 7'h00);
    i_mem.mem[2] = bw(btsc_pkg::OP_SET_BIT, 3'h4, 7'h7f);
    repeat (40) @(posedge ref_clk);
    chk({8'h0, i_mem.regs[7'h7f]}, 16'h009a);
    chk({8'h0, i_mem.regs[7'h00]}, 16'h00ff);
    chk(16'(i_mem.wr_count), 16'h0003);
  endtask
  // skipped word is a set-bit, so a missed flush shows in the register
  task automatic test_skip(input logic [3:0] op, input logic v);
    logic sk;
    sk = (op == btsc_pkg::OP_SKIP_ZERO) ? !v : v;
    restart();
    i_mem.regs[7'h10] = v ? 8'h08 : 8'hf7;
    i_mem.mem[0] = bw(op, 3'h3, 7'h10);
    i_mem.mem[1] = bw(btsc_pkg::OP_SET_BIT, 3'h0, 7'h20);
    i_mem.mem[2] = bw(btsc_pkg::OP_SET_BIT, 3'h1, 7'h20);
    repeat (40) @(posedge ref_clk);
    chk({8'h0, i_mem.regs[7'h20]}, sk ? 16'h0002 : 16'h0003);
    chk(16'(i_mem.wr_count), sk ? 16'h0001 : 16'h0002);
    chk({8'h0, i_mem.regs[7'h10]}, v ? 16'h0008 : 16'h00f7);
  endtask
  task automatic test_call(input logic [10:0] k, input logic [7:0] latch);
    logic [12:0] tgt;
    tgt = {latch[4:3], k};
    restart();
    pc_upper_latch <= latch;
    i_mem.mem[1] = {btsc_pkg::OP_CALL, k};
    i_mem.mem[2] = bw(btsc_pkg::OP_SET_BIT, 3'h2, 7'h30);
    i_mem.mem[tgt] = bw(btsc_pkg::OP_SET_BIT, 3'h5, 7'h30);
    repeat (48) @(posedge ref_clk);
    chk(16'(i_mem.push_count), 16'h0001);
    chk({3'h0, i_mem.last_push}, 16'h0002);
    chk({8'h0, i_mem.regs[7'h30]}, 16'h0020);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    test_phases();
    test_set();
    for (int v = 0; v < 2; v++) begin
      test_skip(btsc_pkg::OP_SKIP_ZERO, v[0]);
      test_skip(btsc_pkg::OP_SKIP_ONE, v[0]);
    end
    test_call(11'h7ff, 8'hf7);
    test_call(11'h000, 8'h08);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- tb/btsc_mem_model.sv ----
// program memory, register file and return stack model
`timescale 1ns/100ps
`default_nettype none
module btsc_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [12:0] prog_addr,
  output logic      [13:0] prog_data,
  input  wire logic [6:0]  file_addr,
  output logic      [7:0]  file_rdata,
  input  wire logic [7:0]  file_wdata,
  input  wire logic        file_we,
  input  wire logic [12:0] return_stack_top,
  input  wire logic        stack_push
);
  logic [13:0] mem [0:8191];
  logic [7:0]  regs [0:127];
  int          wr_count;
  int          push_count;
  logic [12:0] last_push;
  // combinational reads, like asynchronous memories
  assign prog_data  = mem[prog_addr];
  assign file_rdata = regs[file_addr];
  always @(posedge ref_clk) begin
    if (file_we === 1'b1) begin
      regs[file_addr] <= file_wdata;
      wr_count        <= wr_count + 1;
    end
    if (stack_push === 1'b1) begin
      last_push  <= return_stack_top;
      push_count <= push_count + 1;
    end
  end
endmodule
`default_nettype wire
